// *** dram_host_consts.svh ***
/*
  Constants for the parity memory module host: field positions, reset
  levels and timing figures with their cycle counts at a 50 MHz clock.
  Assumes it is included by bare name wherever a figure is needed.
*/
`ifndef DRAM_HOST_CONSTS_SVH
`define DRAM_HOST_CONSTS_SVH

// ------------------------------------------------------------------
// Address and data layout
// ------------------------------------------------------------------
`define DRAM_ADDR_BITS 22
`define DRAM_PIN_ADDR_BITS 11
`define DRAM_COL_LSB 0
`define DRAM_ROW_LSB 11
`define DRAM_DATA_BITS 9
`define DRAM_LANE_BITS 8
`define DRAM_PARITY_BIT 8
`define DRAM_REF_ROW_BITS 10

// ------------------------------------------------------------------
// Reset levels of the pins
// ------------------------------------------------------------------
`define DRAM_STROBE_RST 1'b1
`define DRAM_ADDR_RST 11'h000
`define DRAM_LANE_RST 8'h00

// ------------------------------------------------------------------
// Timing, in ns (refresh period in ms) as printed, and in clock cycles
// ------------------------------------------------------------------
`define DRAM_CLK_NS 20
`define DRAM_CYC_MIN(t) (((t) + `DRAM_CLK_NS - 1) / `DRAM_CLK_NS)
`define DRAM_CYC_MAX(t) ((t) / `DRAM_CLK_NS)
`define DRAM_T_RP_NS 60
`define DRAM_T_RAS_MIN_NS 80
`define DRAM_T_RAS_MAX_NS 10000
`define DRAM_T_RASP_MAX_NS 100000
`define DRAM_T_RCD_NS 20
`define DRAM_T_CAS_NS 20
`define DRAM_T_CAC_NS 20
`define DRAM_T_CP_NS 10
`define DRAM_T_PC_NS 40
`define DRAM_T_CSR_NS 10
`define DRAM_T_WSR_NS 10
`define DRAM_T_REF_MS 16
`define DRAM_REF_ROWS 1024
`define DRAM_READ_SETTLE_CYC 6
`define DRAM_PAGE_MARGIN_CYC 16
`define DRAM_RP_CYC `DRAM_CYC_MIN(`DRAM_T_RP_NS)
`define DRAM_RAS_MIN_CYC `DRAM_CYC_MIN(`DRAM_T_RAS_MIN_NS)
`define DRAM_RCD_CYC `DRAM_CYC_MIN(`DRAM_T_RCD_NS)
`define DRAM_CAS_CYC `DRAM_CYC_MIN(`DRAM_T_CAS_NS)
`define DRAM_READ_CAS_CYC \
  (`DRAM_CYC_MIN(`DRAM_T_CAC_NS) + `DRAM_READ_SETTLE_CYC)
`define DRAM_CP_CYC `DRAM_CYC_MIN(`DRAM_T_CP_NS)
`define DRAM_PC_CYC `DRAM_CYC_MIN(`DRAM_T_PC_NS)
`define DRAM_CSR_CYC `DRAM_CYC_MIN(`DRAM_T_CSR_NS)
`define DRAM_WSR_CYC `DRAM_CYC_MIN(`DRAM_T_WSR_NS)
`define DRAM_RASP_MAX_CYC `DRAM_CYC_MAX(`DRAM_T_RASP_MAX_NS)
`define DRAM_RAS_MAX_CYC `DRAM_CYC_MAX(`DRAM_T_RAS_MAX_NS)
`define DRAM_REF_INTERVAL_CYC \
  `DRAM_CYC_MAX(`DRAM_T_REF_MS * 1000000 / `DRAM_REF_ROWS)

`endif

// *** dram_host_pkg.sv ***
/*
  Types shared by the parity memory module host: controller states, the
  user request and the bundle of pins driven toward the module.
  Assumes dram_host_consts.svh is on the include path.
*/
`include "dram_host_consts.svh"

package dram_host_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ROW, ST_RCD, ST_COL, ST_CAS, ST_CAS_UP, ST_PAGE,
    ST_PRE, ST_CBR_CAS, ST_REF_ROW, ST_REF_RAS
  } ctrl_state_type;

  typedef struct packed {
    logic write;
    logic parity_en;
    logic [`DRAM_ADDR_BITS-1:0] addr;
    logic [`DRAM_DATA_BITS-1:0] data;
  } user_req_type;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic parity_column_strobe_n;
    logic we_n;
    logic [`DRAM_PIN_ADDR_BITS-1:0] multiplexed_addr;
    logic [`DRAM_LANE_BITS-1:0] shared_data_lines_out;
    logic shared_data_lines_oe;
    logic parity_input;
  } dram_pins_type;

endpackage

// *** dram_module_host.sv ***
/*
  Host controller for a 4M x 9 asynchronous memory module: one request at
  a time, same-row page accesses, periodic refresh.
  Assumes the module pins sit directly on the ports, the shared data lines
  are resolved outside from out and oe, and clk runs at 50 MHz.
*/
`timescale 1ns/1ps
`include "dram_host_consts.svh"

// Functional notes
// - Eight shared data lines move together under the shared column strobe.
// - Ninth bit has own input, output and strobe, asserted independently.
// - Issue 1024 refresh cycles, one per row, every 16 ms.
// - Only early writes: write enable low before column strobe falls.
// - Row strobe low at most 10000 ns non-page, 100000 ns in page mode.
// - Column-first refresh: column strobe falls 10 ns before row strobe.
// - Column-first refresh: write enable high 10 ns before row strobe falls.
// - Row-only refresh cycles row strobe with column strobe kept high.
// - Read ends with write enable high until either strobe rises.
// - Page mode allows several columns per row; cycles 40 ns apart.
module dram_module_host #(
  parameter int unsigned PAGE_LIMIT_CYC = `DRAM_RASP_MAX_CYC,
  parameter bit ROW_ONLY_REFRESH = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire dram_host_pkg::user_req_type req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`DRAM_DATA_BITS-1:0] rsp_data,
  output dram_host_pkg::dram_pins_type pins,
  input wire logic [`DRAM_LANE_BITS-1:0] shared_data_lines_in,
  input wire logic parity_output
);

  // ------------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------------
  localparam int unsigned RAS_CNT_BITS = $clog2(PAGE_LIMIT_CYC + 1);
  localparam int unsigned REF_BITS = $clog2(`DRAM_REF_INTERVAL_CYC + 1);

  if (PAGE_LIMIT_CYC <= `DRAM_PAGE_MARGIN_CYC ||
      PAGE_LIMIT_CYC > `DRAM_RASP_MAX_CYC) begin : g_bad_page
    $error("PAGE_LIMIT_CYC out of range");
  end

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  dram_host_pkg::ctrl_state_type state;
  dram_host_pkg::ctrl_state_type next_state;
  dram_host_pkg::user_req_type cur;
  dram_host_pkg::user_req_type next_cur;
  logic [3:0] wait_cnt;
  logic [RAS_CNT_BITS-1:0] ras_cnt;
  logic [REF_BITS-1:0] ref_timer;
  logic ref_pend;
  logic next_ref_pend;
  logic ref_tick;
  logic [`DRAM_REF_ROW_BITS-1:0] ref_row;
  logic held;
  logic take;
  logic done;
  logic same_row;
  logic page_ok;
  logic [`DRAM_DATA_BITS-1:0] sync1;
  logic [`DRAM_DATA_BITS-1:0] sync2;
  logic [`DRAM_DATA_BITS-1:0] sync3;
  logic [`DRAM_DATA_BITS-1:0] filt;

  // Cycles a state lasts; read strobes stay low until the synchronised
  // data has settled, so reads cost more than writes.
  function automatic logic [3:0] hold_cycles(
    input dram_host_pkg::ctrl_state_type st,
    input logic wr
  );
    logic [3:0] n;
    n = 4'h1;
    unique case (st)
      dram_host_pkg::ST_RCD: n = 4'(`DRAM_RCD_CYC);
      dram_host_pkg::ST_CAS: n = wr ? 4'(`DRAM_CAS_CYC)
                                    : 4'(`DRAM_READ_CAS_CYC);
      dram_host_pkg::ST_CAS_UP: n = 4'(`DRAM_CP_CYC);
      dram_host_pkg::ST_PRE: n = 4'(`DRAM_RP_CYC);
      dram_host_pkg::ST_CBR_CAS: n = 4'(`DRAM_CSR_CYC);
      dram_host_pkg::ST_REF_RAS: n = 4'(`DRAM_RAS_MIN_CYC);
      default: n = 4'h1;
    endcase
    return n;
  endfunction

  function automatic logic ras_low_in(
    input dram_host_pkg::ctrl_state_type st
  );
    return st inside {dram_host_pkg::ST_RCD, dram_host_pkg::ST_COL,
                      dram_host_pkg::ST_CAS, dram_host_pkg::ST_CAS_UP,
                      dram_host_pkg::ST_PAGE, dram_host_pkg::ST_REF_RAS};
  endfunction

  // ------------------------------------------------------------------
  // Request acceptance and sequencing
  // ------------------------------------------------------------------
  assign take = req_valid && req_ready;
  assign done = (wait_cnt == 4'h0);
  assign same_row = (req.addr[`DRAM_ADDR_BITS-1:`DRAM_ROW_LSB] ==
                     cur.addr[`DRAM_ADDR_BITS-1:`DRAM_ROW_LSB]);
  // Leave room for one more access before the page-mode ceiling
  assign page_ok = !ref_pend && (ras_cnt <
    RAS_CNT_BITS'(PAGE_LIMIT_CYC - `DRAM_PAGE_MARGIN_CYC));
  assign next_cur = take ? req : cur;
  assign ref_tick = (ref_timer == '0);
  assign next_ref_pend = ref_tick ||
    (ref_pend && !(state == dram_host_pkg::ST_IDLE && !take));

  always_comb begin
    next_state = state;
    unique case (state)
      dram_host_pkg::ST_IDLE: begin
        if (take) begin
          next_state = dram_host_pkg::ST_ROW;
        end else if (ref_pend) begin
          next_state = ROW_ONLY_REFRESH ? dram_host_pkg::ST_REF_ROW
                                        : dram_host_pkg::ST_CBR_CAS;
        end
      end
      dram_host_pkg::ST_ROW:
        if (done) next_state = dram_host_pkg::ST_RCD;
      dram_host_pkg::ST_RCD:
        if (done) next_state = dram_host_pkg::ST_COL;
      dram_host_pkg::ST_COL:
        if (done) next_state = dram_host_pkg::ST_CAS;
      dram_host_pkg::ST_CAS:
        if (done) next_state = dram_host_pkg::ST_CAS_UP;
      dram_host_pkg::ST_CAS_UP: begin
        if (done && ras_cnt >= RAS_CNT_BITS'(`DRAM_RAS_MIN_CYC - 1)) begin
          next_state = dram_host_pkg::ST_PAGE;
        end
      end
      dram_host_pkg::ST_PAGE: begin
        if (take && same_row && page_ok) begin
          next_state = dram_host_pkg::ST_COL;
        end else begin
          next_state = dram_host_pkg::ST_PRE;
        end
      end
      dram_host_pkg::ST_PRE: begin
        if (done) begin
          next_state = held ? dram_host_pkg::ST_ROW
                            : dram_host_pkg::ST_IDLE;
        end
      end
      dram_host_pkg::ST_CBR_CAS:
        if (done) next_state = dram_host_pkg::ST_REF_RAS;
      dram_host_pkg::ST_REF_ROW:
        if (done) next_state = dram_host_pkg::ST_REF_RAS;
      dram_host_pkg::ST_REF_RAS:
        if (done) next_state = dram_host_pkg::ST_PRE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= dram_host_pkg::ST_IDLE;
      wait_cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        wait_cnt <= hold_cycles(next_state, next_cur.write) - 4'h1;
      end else if (!done) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end

  // A request taken while a row closes is kept and replayed afterwards
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
      held <= 1'b0;
    end else begin
      cur <= next_cur;
      if (state == dram_host_pkg::ST_PAGE && take &&
          next_state == dram_host_pkg::ST_PRE) begin
        held <= 1'b1;
      end else if (state == dram_host_pkg::ST_PRE &&
                   next_state == dram_host_pkg::ST_ROW) begin
        held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= !next_ref_pend && !held &&
        (next_state == dram_host_pkg::ST_IDLE ||
         next_state == dram_host_pkg::ST_PAGE);
    end
  end

  // ------------------------------------------------------------------
  // Row strobe low-time tracking
  // ------------------------------------------------------------------
  // Single accesses close after one column, far inside the non-page limit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ras_cnt <= '0;
    end else if (pins.ras_n) begin
      ras_cnt <= '0;
    end else if (ras_cnt != '1) begin
      ras_cnt <= ras_cnt + RAS_CNT_BITS'(1);
    end
  end

  // ------------------------------------------------------------------
  // Refresh scheduling
  // ------------------------------------------------------------------
  // Set wins over clear so a tick during refresh start is kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_timer <= REF_BITS'(`DRAM_REF_INTERVAL_CYC - 1);
      ref_pend <= 1'b0;
      ref_row <= '0;
    end else begin
      ref_pend <= next_ref_pend;
      if (ref_tick) begin
        ref_timer <= REF_BITS'(`DRAM_REF_INTERVAL_CYC - 1);
      end else begin
        ref_timer <= ref_timer - REF_BITS'(1);
      end
      if (state == dram_host_pkg::ST_REF_RAS && done) begin
        ref_row <= ref_row + `DRAM_REF_ROW_BITS'(1);
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins.ras_n <= `DRAM_STROBE_RST;
      pins.cas_n <= `DRAM_STROBE_RST;
      pins.parity_column_strobe_n <= `DRAM_STROBE_RST;
      pins.we_n <= `DRAM_STROBE_RST;
      pins.multiplexed_addr <= `DRAM_ADDR_RST;
      pins.shared_data_lines_out <= `DRAM_LANE_RST;
      pins.shared_data_lines_oe <= 1'b0;
      pins.parity_input <= 1'b0;
    end else begin
      pins.ras_n <= !ras_low_in(next_state);
      // Column-first refresh drops both column strobes a cycle early
      pins.cas_n <= !(next_state == dram_host_pkg::ST_CAS ||
        (!ROW_ONLY_REFRESH &&
         next_state inside {dram_host_pkg::ST_CBR_CAS,
                            dram_host_pkg::ST_REF_RAS}));
      pins.parity_column_strobe_n <=
        !((next_state == dram_host_pkg::ST_CAS && next_cur.parity_en) ||
          (!ROW_ONLY_REFRESH &&
           next_state inside {dram_host_pkg::ST_CBR_CAS,
                              dram_host_pkg::ST_REF_RAS}));
      // Write enable falls with the row phase (with the column address for a
      // page access), before the column strobe, and stays high for reads and refresh
      pins.we_n <= !(next_cur.write &&
        next_state inside {dram_host_pkg::ST_ROW, dram_host_pkg::ST_RCD,
                           dram_host_pkg::ST_COL, dram_host_pkg::ST_CAS,
                           dram_host_pkg::ST_CAS_UP});
      if (next_state inside {dram_host_pkg::ST_ROW,
                             dram_host_pkg::ST_RCD}) begin
        pins.multiplexed_addr <=
          next_cur.addr[`DRAM_ADDR_BITS-1:`DRAM_ROW_LSB];
      end else if (next_state inside {dram_host_pkg::ST_COL,
                                      dram_host_pkg::ST_CAS}) begin
        pins.multiplexed_addr <=
          next_cur.addr[`DRAM_ROW_LSB-1:`DRAM_COL_LSB];
      end else if (next_state == dram_host_pkg::ST_REF_ROW) begin
        pins.multiplexed_addr <= {1'b0, ref_row};
      end
      // Lines are driven only for a write, released as the strobe rises
      pins.shared_data_lines_oe <= next_cur.write &&
        next_state inside {dram_host_pkg::ST_ROW, dram_host_pkg::ST_RCD,
                           dram_host_pkg::ST_COL,
                           dram_host_pkg::ST_CAS};
      pins.shared_data_lines_out <= next_cur.data[`DRAM_LANE_BITS-1:0];
      pins.parity_input <= next_cur.data[`DRAM_PARITY_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Read capture
  // ------------------------------------------------------------------
  // Three stages; a bit is taken once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
    end else begin
      sync1 <= {parity_output, shared_data_lines_in};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
    end
  end

  // Parity reads as zero when its strobe was left high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state == dram_host_pkg::ST_CAS && done && !cur.write) begin
        rsp_valid <= 1'b1;
        rsp_data <= {filt[`DRAM_PARITY_BIT] & cur.parity_en,
                     filt[`DRAM_LANE_BITS-1:0]};
      end
    end
  end

endmodule

// *** dram_host_sva.sv ***
/*
  Checker for the memory module host: strobe order and timing at 50 MHz.
  Assumes it is bound to dram_module_host and sees only its ports.
*/
`timescale 1ns/1ps
`include "dram_host_consts.svh"
module dram_host_sva #(
  parameter int unsigned PAGE_LIMIT_CYC = 5000,
  parameter bit ROW_ONLY_REFRESH = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire dram_host_pkg::user_req_type req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [`DRAM_DATA_BITS-1:0] rsp_data,
  input wire dram_host_pkg::dram_pins_type pins,
  input wire logic [`DRAM_LANE_BITS-1:0] shared_data_lines_in,
  input wire logic parity_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  int unsigned ras_low;
  int unsigned since_ref;
  // ----
  // Counters: row strobe low time, gap between refreshes
  // ----
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ras_low <= 0;
    else if (pins.ras_n) ras_low <= 0;
    else ras_low <= ras_low + 1;
  end
  // Slack covers an access in flight plus a full page budget
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) since_ref <= 0;
    else if (!pins.ras_n && !pins.cas_n && ras_low == 0) since_ref <= 0;
    else since_ref <= since_ref + 1;
  end
  chk_early_write: assert property (
    $fell(pins.cas_n) && !pins.we_n |-> $past(pins.we_n) == 1'b0)
    else $error("write enable late for write");
  chk_lane_drive: assert property (
    !pins.cas_n && !pins.ras_n |-> pins.shared_data_lines_oe == !pins.we_n)
    else $error("lane drive wrong under column strobe");
  chk_parity_write: assert property (
    !pins.parity_column_strobe_n && !pins.we_n
      |-> !pins.cas_n && $stable(pins.parity_input))
    else $error("parity write not held");
  chk_cbr_setup: assert property (
    $fell(pins.ras_n) && !pins.cas_n |-> $past(pins.cas_n) == 1'b0)
    else $error("column strobe late before refresh");
  chk_cbr_we_high: assert property (
    $fell(pins.ras_n) && !pins.cas_n |-> $past(pins.we_n) && pins.we_n)
    else $error("write enable low in refresh");
  chk_read_we_hold: assert property (
    !pins.cas_n && pins.we_n && !pins.ras_n |=> pins.we_n || pins.cas_n)
    else $error("write enable fell during read");
  chk_col_after_row: assert property (
    $fell(pins.cas_n) && !pins.ras_n
      |-> $past(pins.ras_n) == 1'b0 && $stable(pins.multiplexed_addr))
    else $error("column strobe too early");
  chk_read_answer: assert property (
    $fell(pins.cas_n) && pins.we_n && !pins.ras_n
      |-> !rsp_valid [*7] ##1 rsp_valid)
    else $error("read answer not on time");
  chk_row_low_max: assert property (
    ras_low < PAGE_LIMIT_CYC)
    else $error("row strobe low too long");
  chk_refresh_gap: assert property (
    ROW_ONLY_REFRESH ||
      since_ref <= `DRAM_REF_INTERVAL_CYC + PAGE_LIMIT_CYC + 24)
    else $error("refresh overdue");
endmodule

bind dram_module_host dram_host_sva #(
  .PAGE_LIMIT_CYC(PAGE_LIMIT_CYC),
  .ROW_ONLY_REFRESH(ROW_ONLY_REFRESH)
) u_dram_host_sva (
  .clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .pins(pins), .shared_data_lines_in(shared_data_lines_in),
  .parity_output(parity_output)
);

// *** dram_module_model.sv ***
/*
  Behavioural 4M x 9 memory module reacting to strobe edges.
  Assumes the lanes input is the resolved level of the eight shared lines.
*/
`timescale 1ns/1ps
`include "dram_host_consts.svh"
module dram_module_model (
  input wire dram_host_pkg::dram_pins_type pins,
  input wire logic [`DRAM_LANE_BITS-1:0] lanes,
  output logic [`DRAM_LANE_BITS-1:0] lanes_out,
  output logic lanes_oe,
  output logic parity_output,
  output int unsigned row_opens,
  output int unsigned refreshes
);
  logic [`DRAM_LANE_BITS-1:0] lane_mem [logic [21:0]];
  logic par_mem [logic [21:0]];
  logic [10:0] row = 11'h000;
  logic [9:0] ref_row = 10'h000;
  initial begin
    lanes_out = 8'h5a;
    lanes_oe = 1'b0;
    parity_output = 1'b0;
    row_opens = 0;
    refreshes = 0;
  end
  // ----
  // Row strobe: latch a row, or refresh from the own counter
  // ----
  always @(negedge pins.ras_n) begin
    if (!pins.cas_n) begin
      ref_row <= ref_row + 10'h001;
      refreshes <= refreshes + 1;
    end else begin
      row <= pins.multiplexed_addr;
      row_opens <= row_opens + 1;
    end
  end
  // Released lanes show the inverse of the last value, never a held copy
  always @(negedge pins.cas_n) begin
    if (!pins.ras_n) begin
      if (!pins.we_n) lane_mem[{row, pins.multiplexed_addr}] = lanes;
      else begin
        lanes_oe <= #15 1'b1;
        lanes_out <= #15 lane_mem.exists({row, pins.multiplexed_addr}) ?
          lane_mem[{row, pins.multiplexed_addr}] : 8'ha5;
      end
    end
  end
  always @(posedge pins.cas_n) begin
    lanes_oe <= 1'b0;
    lanes_out <= ~lanes_out;
  end
  always @(negedge pins.parity_column_strobe_n) begin
    if (!pins.ras_n) begin
      if (!pins.we_n) par_mem[{row, pins.multiplexed_addr}] = pins.parity_input;
      else parity_output <= #15 par_mem.exists({row, pins.multiplexed_addr}) ?
        par_mem[{row, pins.multiplexed_addr}] : 1'b1;
    end
  end
  always @(posedge pins.parity_column_strobe_n) begin
    parity_output <= ~parity_output;
  end
endmodule

// *** parity_dram_module_access_test.sv ***
/*
  Self-checking bench for the memory module host against a module model.
  Assumes the package, constants, checker and model files compile first.
*/
`timescale 1ns/1ps
`include "dram_host_consts.svh"
module parity_dram_module_access_test;
  logic clk;
  logic resetn;
  logic req_valid;
  dram_host_pkg::user_req_type req;
  logic req_ready;
  logic rsp_valid;
  logic [`DRAM_DATA_BITS-1:0] rsp_data;
  dram_host_pkg::dram_pins_type pins;
  logic [`DRAM_LANE_BITS-1:0] lanes;
  logic [`DRAM_LANE_BITS-1:0] model_lanes;
  logic model_oe;
  logic parity_output;
  int unsigned row_opens;
  int unsigned refreshes;
  dram_host_pkg::dram_pins_type pins_rows;
  logic [`DRAM_LANE_BITS-1:0] lanes_rows;
  logic parity_rows;
  int unsigned opens_rows;
  int unsigned refreshes_rows;
  int unsigned mismatches = 0;
  int unsigned tests_run = 0;
  int unsigned cycles = 0;
  logic [`DRAM_DATA_BITS-1:0] rsp_q [$];

  assign lanes = pins.shared_data_lines_oe ? pins.shared_data_lines_out
                                           : model_lanes;
  // Short page budget keeps runs small; margin of 16 still fits
  dram_module_host #(.PAGE_LIMIT_CYC(200), .ROW_ONLY_REFRESH(1'b0))
    u_dram_module_host (.clk(clk), .resetn(resetn), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .pins(pins), .shared_data_lines_in(lanes),
    .parity_output(parity_output));
  dram_module_model u_dram_module_model (.pins(pins), .lanes(lanes),
    .lanes_out(model_lanes), .lanes_oe(model_oe),
    .parity_output(parity_output), .row_opens(row_opens),
    .refreshes(refreshes));
  // Second host runs row-only refresh with no traffic, same reset
  dram_module_host #(.PAGE_LIMIT_CYC(200), .ROW_ONLY_REFRESH(1'b1))
    u_dram_module_host_rows (.clk(clk), .resetn(resetn), .req_valid(1'b0),
    .req('0), .req_ready(), .rsp_valid(), .rsp_data(), .pins(pins_rows),
    .shared_data_lines_in(lanes_rows), .parity_output(parity_rows));
  dram_module_model u_dram_module_model_rows (.pins(pins_rows),
    .lanes(lanes_rows), .lanes_out(lanes_rows), .lanes_oe(),
    .parity_output(parity_rows), .row_opens(opens_rows),
    .refreshes(refreshes_rows));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Request stays up until the edge that takes it; valid is left high
  task issue(input logic wr, input logic par, input logic [21:0] a,
             input logic [8:0] d);
    req_valid = 1'b1;
    req = {wr, par, a, d};
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask
  task expect_rsp(input string what, input logic [8:0] exp);
    int n;
    n = 0;
    while (rsp_q.size() == 0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(what, rsp_q.size() > 0 ? rsp_q.pop_front() : 9'hxxx, exp);
  endtask
  task wait_refresh();
    int unsigned r;
    r = refreshes;
    while (refreshes == r) @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
    if (model_oe === 1'b1) begin
      check("contention", pins.shared_data_lines_oe, 1'b0);
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      mismatches++;
      conclude();
    end
  end
  // ----
  // Scenarios
  // ----
  task t_reset();
    check("ras_n", pins.ras_n, 1'b1);
    check("cas_n", pins.cas_n, 1'b1);
    check("par strobe", pins.parity_column_strobe_n, 1'b1);
    check("lane oe", pins.shared_data_lines_oe, 1'b0);
    check("ready in reset", req_ready, 1'b0);
  endtask
  task t_ends();
    issue(1'b1, 1'b1, 22'h3fffff, 9'h1a5);
    issue(1'b1, 1'b1, 22'h000000, 9'h05a);
    issue(1'b0, 1'b1, 22'h3fffff, 9'h000);
    issue(1'b0, 1'b1, 22'h000000, 9'h000);
    issue(1'b0, 1'b0, 22'h3fffff, 9'h000);
    req_valid = 1'b0;
    expect_rsp("rd last word", 9'h1a5);
    expect_rsp("rd first word", 9'h05a);
    expect_rsp("rd no parity", 9'h0a5);
  endtask
  task t_page();
    int unsigned opens;
    int i;
    wait_refresh();
    opens = row_opens;
    for (i = 0; i < 8; i++) begin
      issue(1'b1, 1'b1, {11'h155, 11'(i)}, 9'(9'h100 + i * 3));
    end
    for (i = 0; i < 8; i++) issue(1'b0, 1'b1, {11'h155, 11'(i)}, 9'h000);
    req_valid = 1'b0;
    for (i = 0; i < 8; i++) expect_rsp("page rd", 9'(9'h100 + i * 3));
    check("row opens", row_opens - opens, 1);
  endtask
  // Both hosts tick together, so their refreshes land on the same edge
  task t_refresh();
    int unsigned r;
    int unsigned o;
    logic [10:0] row0;
    wait_refresh();
    r = refreshes;
    o = opens_rows;
    row0 = u_dram_module_model_rows.row;
    repeat (1600) @(negedge clk);
    check("refresh count", refreshes - r, 2);
    check("row-only refreshes", opens_rows - o, 2);
    check("row-only rows", 11'(u_dram_module_model_rows.row - row0), 2);
    check("row-only no cbr", refreshes_rows, 0);
  endtask
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (10) @(negedge clk);
    t_reset();
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    check("ready after reset", req_ready, 1'b1);
    t_ends();
    t_page();
    t_refresh();
    conclude();
  end
endmodule
